// ==== hdl/stpcfg_pkg.sv ====
// Package with register map, field layout and decode tables of the step-charge configuration
package stpcfg_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] STPCFG_ADDR_THRESHOLD   = 8'h13;
  localparam logic [7:0] STPCFG_ADDR_CURRENT     = 8'h14;

  // ==========================================================
  // Field layout
  localparam int         STPCFG_HYS_LSB          = 4;
  localparam int         STPCFG_HYS_W            = 3;
  localparam int         STPCFG_RISE_LSB         = 0;
  localparam int         STPCFG_RISE_W           = 4;
  localparam int         STPCFG_UVLO_LSB         = 3;
  localparam int         STPCFG_UVLO_W           = 2;
  localparam int         STPCFG_FRAC_LSB         = 0;
  localparam int         STPCFG_FRAC_W           = 3;
  localparam logic [7:0] STPCFG_THRESHOLD_MASK   = 8'h7f;
  localparam logic [7:0] STPCFG_CURRENT_MASK     = 8'h1f;

  // ==========================================================
  // Values after reset; the four field values also after an input-present edge
  localparam logic [2:0] STPCFG_HYS_RESET        = 3'h0;
  localparam logic [3:0] STPCFG_RISE_RESET       = 4'h0;
  localparam logic [1:0] STPCFG_UVLO_RESET       = 2'h0;
  localparam logic [2:0] STPCFG_FRAC_RESET       = 3'h0;
  localparam logic [3:0] STPCFG_FULL_TENTHS      = 4'ha;
  localparam logic [7:0] STPCFG_READ_RESET       = 8'h00;

  // ==========================================================
  // Decode scales
  localparam logic [9:0] STPCFG_HYS_STEP_MV      = 10'h064;
  localparam logic [2:0] STPCFG_HYS_MAX_CODE     = 3'h5;
  localparam logic [5:0] STPCFG_RISE_STEP_MV     = 6'h32;
  localparam logic [3:0] STPCFG_FRAC_BASE_TENTHS = 4'h2;

  // Edge selection for the input-present reset
  typedef enum logic [1:0] {
    STPCFG_EDGE_RISE,
    STPCFG_EDGE_FALL,
    STPCFG_EDGE_BOTH,
    STPCFG_EDGE_NONE
  } stpcfg_edge_t;

endpackage : stpcfg_pkg

// ==== hdl/stpcfg_edge_det.sv ====
// Synchroniser and selectable edge detector for the charger input-present pin
`timescale 1ns/1ps

module stpcfg_edge_det (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   pin,
  input  wire stpcfg_pkg::stpcfg_edge_t edge_sel,
  output logic                        edge_pulse
);
  import stpcfg_pkg::*;

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic prev_q,  prev_d;
  logic edge_q,  edge_d;

  always_comb begin
    sync1_d = pin;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
    unique case (edge_sel)
      STPCFG_EDGE_RISE: edge_d = sync2_q & ~prev_q;
      STPCFG_EDGE_FALL: edge_d = ~sync2_q & prev_q;
      STPCFG_EDGE_BOTH: edge_d = sync2_q ^ prev_q;
      STPCFG_EDGE_NONE: edge_d = 1'b0;
    endcase
  end

  // Prev starts low so a pin already high at reset release reads as a rising edge
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      edge_q  <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
      edge_q  <= edge_d;
    end
  end

  assign edge_pulse = edge_q;

  edge_source_a: assert property (@(posedge clk) disable iff (reset) // R1
    edge_q |-> $past(sync2_q) != $past(prev_q))
    else $error("edge pulse without a pin change");
  edge_masked_a: assert property (@(posedge clk) disable iff (reset) // R1
    $past(edge_sel) == STPCFG_EDGE_NONE |-> !edge_q)
    else $error("edge pulse while edges are ignored");
  edge_rise_a: assert property (@(posedge clk) disable iff (reset) // R1
    (edge_q && $past(edge_sel) == STPCFG_EDGE_RISE) |-> $past(sync2_q))
    else $error("rising select pulsed on a falling pin");

endmodule : stpcfg_edge_det

// ==== hdl/stpcfg_regs.sv ====
// Step-charge configuration register pair with decoded threshold and current outputs
// Notes on behaviour
// [R1] Both registers return to defaults on the selected input-present edge.
// [R2] Hysteresis field bits 6:4, codes 0..5 give 100..600 mV; 6,7 reserved.
// [R3] Rising threshold field bits 3:0, sixteen ascending codes 50 mV apart.
// [R4] Undervoltage field bits 4:3: 2.7, 2.9, 3.0, 3.2 V.
// [R5] Current fraction field bits 2:0: 0.2 plus 0.1 per code.
// [R6] Above threshold, current is the smaller of step and thermistor fractions, or the step fraction when thermistor is zero.
// [R7] Writable fields read back as written; unused bits read zero.
`timescale 1ns/1ps

module stpcfg_regs (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  input  wire logic [7:0]               addr,
  input  wire logic [7:0]               wr_data,
  output logic      [7:0]               rd_data,
  input  wire logic                     charger_input_present,
  input  wire stpcfg_pkg::stpcfg_edge_t input_valid_edge_select,
  input  wire logic                     above_step_threshold,
  input  wire logic [3:0]               thermistor_fraction_tenths,
  output logic      [2:0]               step_hysteresis_sel,
  output logic      [3:0]               step_rising_threshold_sel,
  output logic      [1:0]               system_undervoltage_threshold_sel,
  output logic      [2:0]               step_current_fraction_sel,
  output logic      [9:0]               step_hysteresis_mv,
  output logic      [9:0]               step_rise_offset_mv,
  output logic      [1:0]               uvlo_level_code,
  output logic      [3:0]               fast_charge_fraction_tenths
);
  import stpcfg_pkg::*;

  // ==========================================================
  // Input-present edge
  logic chg_edge;

  stpcfg_edge_det u_stpcfg_edge_det (
    .clk        (clk),
    .reset      (reset),
    .pin        (charger_input_present),
    .edge_sel   (input_valid_edge_select),
    .edge_pulse (chg_edge)
  );

  // ==========================================================
  // Register state
  logic [2:0] hys_q,  hys_d;
  logic [3:0] rise_q, rise_d;
  logic [1:0] uvlo_q, uvlo_d;
  logic [2:0] frac_q, frac_d;
  // Read byte sits in a flop so it stands until the next read
  logic [7:0] rd_q,   rd_d;

  always_comb begin
    hys_d  = hys_q;
    rise_d = rise_q;
    uvlo_d = uvlo_q;
    frac_d = frac_q;
    rd_d   = rd_q;
    // Edge reset wins over a write in the same cycle
    if (chg_edge) begin
      hys_d  = STPCFG_HYS_RESET; // R1
      rise_d = STPCFG_RISE_RESET; // R1
      uvlo_d = STPCFG_UVLO_RESET; // R1
      frac_d = STPCFG_FRAC_RESET; // R1
    end else if (wr_en) begin
      if (addr == STPCFG_ADDR_THRESHOLD) begin
        hys_d  = wr_data[STPCFG_HYS_LSB +: STPCFG_HYS_W]; // R2
        rise_d = wr_data[STPCFG_RISE_LSB +: STPCFG_RISE_W]; // R3
      end else if (addr == STPCFG_ADDR_CURRENT) begin
        uvlo_d = wr_data[STPCFG_UVLO_LSB +: STPCFG_UVLO_W]; // R4
        frac_d = wr_data[STPCFG_FRAC_LSB +: STPCFG_FRAC_W]; // R5
      end
    end
    // A read in the same cycle as a write returns the old contents
    if (rd_en) begin
      if (addr == STPCFG_ADDR_THRESHOLD) begin
        rd_d = {1'b0, hys_q, rise_q}; // R7
      end else if (addr == STPCFG_ADDR_CURRENT) begin
        rd_d = {3'h0, uvlo_q, frac_q}; // R7
      end else begin
        rd_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hys_q  <= STPCFG_HYS_RESET;
      rise_q <= STPCFG_RISE_RESET;
      uvlo_q <= STPCFG_UVLO_RESET;
      frac_q <= STPCFG_FRAC_RESET;
      rd_q   <= STPCFG_READ_RESET;
    end else begin
      hys_q  <= hys_d;
      rise_q <= rise_d;
      uvlo_q <= uvlo_d;
      frac_q <= frac_d;
      rd_q   <= rd_d;
    end
  end

  // ==========================================================
  // Decoded outputs
  logic [9:0] hys_mv_q,  hys_mv_d;
  logic [9:0] rise_mv_q, rise_mv_d;
  logic [3:0] fchg_q,    fchg_d;
  logic [3:0] step_tenths;

  always_comb begin
    // Reserved hysteresis codes report zero so the analog side can flag them
    if (hys_q <= STPCFG_HYS_MAX_CODE) begin
      hys_mv_d = (10'(hys_q) + 10'h001) * STPCFG_HYS_STEP_MV; // R2
    end else begin
      hys_mv_d = 10'h000; // R2
    end
    rise_mv_d   = 10'(rise_q) * 10'(STPCFG_RISE_STEP_MV); // R3
    // Codes map to two through nine tenths, so the step value is never zero
    step_tenths = 4'(frac_q) + STPCFG_FRAC_BASE_TENTHS; // R5
    // Zero from the thermistor side means no reduction requested
    fchg_d      = thermistor_fraction_tenths;
    if (above_step_threshold) begin
      if (thermistor_fraction_tenths == 4'h0 ||
          step_tenths < thermistor_fraction_tenths) begin
        fchg_d = step_tenths; // R6
      end
    end else if (thermistor_fraction_tenths == 4'h0) begin
      fchg_d = STPCFG_FULL_TENTHS;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hys_mv_q  <= STPCFG_HYS_STEP_MV;
      rise_mv_q <= 10'h000;
      fchg_q    <= STPCFG_FULL_TENTHS;
    end else begin
      hys_mv_q  <= hys_mv_d;
      rise_mv_q <= rise_mv_d;
      fchg_q    <= fchg_d;
    end
  end

  assign step_hysteresis_sel               = hys_q;
  assign step_rising_threshold_sel         = rise_q;
  assign system_undervoltage_threshold_sel = uvlo_q; // R4
  assign step_current_fraction_sel         = frac_q;
  assign uvlo_level_code                   = uvlo_q; // R4
  assign step_hysteresis_mv                = hys_mv_q;
  assign step_rise_offset_mv               = rise_mv_q;
  assign fast_charge_fraction_tenths       = fchg_q;
  assign rd_data                           = rd_q;

  // ==========================================================
  // Checks on the register pair
  // Writes, holds and the edge clear
  edge_clears_all_a: assert property (@(posedge clk) disable iff (reset) // R1
    chg_edge |=> (hys_q == 3'h0 && rise_q == 4'h0 && uvlo_q == 2'h0 && frac_q == 3'h0))
    else $error("fields not defaulted after input edge");
  thr_write_a: assert property (@(posedge clk) disable iff (reset) // R2
    (wr_en && !chg_edge && addr == 8'h13) |=> {hys_q, rise_q} == $past(wr_data[6:0]))
    else $error("threshold write not stored");
  cur_write_a: assert property (@(posedge clk) disable iff (reset) // R4
    (wr_en && !chg_edge && addr == 8'h14) |=> {uvlo_q, frac_q} == $past(wr_data[4:0]))
    else $error("current write not stored");
  fields_hold_a: assert property (@(posedge clk) disable iff (reset) // R7
    (!wr_en && !chg_edge) |=> $stable({hys_q, rise_q, uvlo_q, frac_q}))
    else $error("fields changed without a write");
  unmapped_write_a: assert property (@(posedge clk) disable iff (reset) // R7
    (wr_en && !chg_edge && addr != 8'h13 && addr != 8'h14) |=>
      $stable({hys_q, rise_q, uvlo_q, frac_q}))
    else $error("unmapped write changed a field");

  // Read port
  read_zero_a: assert property (@(posedge clk) disable iff (reset) // R7
    (rd_en && addr == 8'h14) |=> rd_data[7:5] == 3'b000 && rd_data[4:0] == $past({uvlo_q, frac_q}))
    else $error("current register readback wrong");
  read_thr_a: assert property (@(posedge clk) disable iff (reset) // R7
    (rd_en && addr == 8'h13) |=> rd_data == {1'b0, $past(hys_q), $past(rise_q)})
    else $error("threshold register readback wrong");
  read_unmapped_a: assert property (@(posedge clk) disable iff (reset) // R7
    (rd_en && addr != 8'h13 && addr != 8'h14) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  read_hold_a: assert property (@(posedge clk) disable iff (reset) // R7
    !rd_en |=> $stable(rd_data))
    else $error("read data changed without a read");

  // ==========================================================
  // Checks on the decoded outputs
  // Decodes trail the fields by one cycle
  hys_decode_a: assert property (@(posedge clk) disable iff (reset) // R2
    (hys_q == 3'h5 && $stable(hys_q)) |=> hys_mv_q == 10'd600)
    else $error("hysteresis code 5 not 600 mV");
  hys_step_a: assert property (@(posedge clk) disable iff (reset) // R2
    (hys_q <= 3'h5) |=> hys_mv_q == 10'd100 * (10'($past(hys_q)) + 10'd1))
    else $error("hysteresis not 100 mV per code");
  hys_reserved_a: assert property (@(posedge clk) disable iff (reset) // R2
    (hys_q[2:1] == 2'b11) |=> hys_mv_q == 10'd0)
    else $error("reserved hysteresis code decoded");
  rise_decode_a: assert property (@(posedge clk) disable iff (reset) // R3
    1'b1 |=> rise_mv_q == 10'($past(rise_q)) * 10'd50)
    else $error("rising offset not 50 mV per code");

  // Fraction selection; zero from the thermistor side means no cap
  frac_decode_a: assert property (@(posedge clk) disable iff (reset) // R5
    (above_step_threshold && thermistor_fraction_tenths == 4'h0) |=>
      fchg_q == 4'($past(frac_q)) + 4'd2)
    else $error("step fraction not two tenths plus code");
  step_min_a: assert property (@(posedge clk) disable iff (reset) // R6
    above_step_threshold |=> fchg_q <= 4'($past(frac_q)) + 4'd2)
    else $error("step current fraction exceeded");
  therm_cap_a: assert property (@(posedge clk) disable iff (reset) // R6
    (above_step_threshold && thermistor_fraction_tenths != 4'h0) |=>
      fchg_q <= $past(thermistor_fraction_tenths))
    else $error("thermistor fraction exceeded above step");
  below_therm_a: assert property (@(posedge clk) disable iff (reset) // R6
    (!above_step_threshold && thermistor_fraction_tenths != 4'h0) |=>
      fchg_q == $past(thermistor_fraction_tenths))
    else $error("thermistor fraction not used below step");
  below_full_a: assert property (@(posedge clk) disable iff (reset) // R6
    (!above_step_threshold && thermistor_fraction_tenths == 4'h0) |=> fchg_q == 4'ha)
    else $error("full fraction not used below step");

endmodule : stpcfg_regs

// ==== bench/stpcfg_regs_tb.sv ====
// Self-checking bench for the step-charge configuration register pair
`timescale 1ns/1ps

module step_charge_config_regs_tb;
  import stpcfg_pkg::*;

  // ==========================================================
  // Stimulus and design
  logic         clk     = 1'b0;
  logic         reset   = 1'b1;
  logic         wr_en   = 1'b0;
  logic         rd_en   = 1'b0;
  logic         pin     = 1'b0;
  logic         above   = 1'b0;
  logic [7:0]   addr    = 8'h00;
  logic [7:0]   wr_data = 8'h00;
  logic [3:0]   therm   = 4'h0;
  stpcfg_edge_t edge_sel = STPCFG_EDGE_RISE;
  logic [7:0]   rd_data, rv;
  logic [3:0]   rise_sel, frac;
  logic [2:0]   hys_sel, cur_sel;
  logic [1:0]   uvlo_sel, uvlo_code;
  logic [9:0]   hys_mv, rise_mv;
  int           num_errors = 0;
  int           tests_run  = 0;

  always #10 clk = ~clk;

  stpcfg_regs u_stpcfg_regs (
    .clk(clk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .charger_input_present(pin),
    .input_valid_edge_select(edge_sel), .above_step_threshold(above),
    .thermistor_fraction_tenths(therm), .step_hysteresis_sel(hys_sel),
    .step_rising_threshold_sel(rise_sel), .system_undervoltage_threshold_sel(uvlo_sel),
    .step_current_fraction_sel(cur_sel), .step_hysteresis_mv(hys_mv),
    .step_rise_offset_mv(rise_mv), .uvlo_level_code(uvlo_code),
    .fast_charge_fraction_tenths(frac)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Two extra edges after the field lands on the write edge: registered decode lands, then one spare
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    cyc(2);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    cyc(1);
    rv = rd_data;
  endtask : rd

  // ==========================================================
  // Scenarios
  task automatic t_thresh();
    for (int c = 0; c < 8; c++) begin
      wr(STPCFG_ADDR_THRESHOLD, {1'b1, 3'(c), 4'(15 - c)});
      chk("hys field", 10'(c), hys_sel);
      chk("hys mv", (c < 6) ? 10'((c + 1) * 100) : 10'h000, hys_mv);
      chk("rise field", 10'(15 - c), rise_sel);
      chk("rise mv", 10'((15 - c) * 50), rise_mv);
      rd(STPCFG_ADDR_THRESHOLD);
      chk("thresh read", {2'h0, 1'b0, 3'(c), 4'(15 - c)}, rv);
    end
    $display("done: threshold register");
  endtask : t_thresh

  task automatic t_current();
    @(posedge clk);
    above <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(STPCFG_ADDR_CURRENT, {3'b111, 2'(c), 3'(c)});
      chk("uvlo field", 10'(c % 4), uvlo_sel);
      chk("uvlo code", 10'(c % 4), uvlo_code);
      chk("frac field", 10'(c), cur_sel);
      chk("fraction", 10'(c + 2), frac);
      rd(STPCFG_ADDR_CURRENT);
      chk("current read", {5'h00, 2'(c), 3'(c)}, rv);
    end
    wr(STPCFG_ADDR_CURRENT, 8'h03);
    wr(8'h20, 8'hff);
    rd(8'h20);
    chk("unmapped read", 10'h000, rv);
    chk("frac kept", 10'h003, cur_sel);
    @(posedge clk);
    therm <= 4'h4;
    cyc(2);
    chk("min therm", 10'h004, frac);
    @(posedge clk);
    therm <= 4'h7;
    cyc(2);
    chk("min step", 10'h005, frac);
    @(posedge clk);
    above <= 1'b0;
    cyc(2);
    chk("below step", 10'h007, frac);
    $display("done: current register");
  endtask : t_current

  task automatic t_edge(input stpcfg_edge_t s, input logic lvl, input logic clr);
    @(posedge clk);
    edge_sel <= s;
    wr(STPCFG_ADDR_THRESHOLD, 8'h25);
    wr(STPCFG_ADDR_CURRENT, 8'h1d);
    @(posedge clk);
    pin <= lvl;
    cyc(8);
    chk("hys after edge", clr ? 10'h000 : 10'h002, hys_sel);
    chk("rise after edge", clr ? 10'h000 : 10'h005, rise_sel);
    chk("uvlo after edge", clr ? 10'h000 : 10'h003, uvlo_sel);
    chk("frac after edge", clr ? 10'h000 : 10'h005, cur_sel);
    $display("done: input edge case");
  endtask : t_edge

  // ==========================================================
  // Verdict, watchdog and main sequence
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    #100000;
    num_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    results();
  end

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    cyc(2);
    chk("reset hys mv", 10'd100, hys_mv);
    chk("reset fraction", 10'd10, frac);
    rd(STPCFG_ADDR_THRESHOLD);
    chk("reset read", 10'h000, rv);
    t_thresh();
    t_current();
    t_edge(STPCFG_EDGE_RISE, 1'b1, 1'b1);
    t_edge(STPCFG_EDGE_NONE, 1'b0, 1'b0);
    t_edge(STPCFG_EDGE_FALL, 1'b1, 1'b0);
    t_edge(STPCFG_EDGE_FALL, 1'b0, 1'b1);
    t_edge(STPCFG_EDGE_BOTH, 1'b1, 1'b1);
    t_edge(STPCFG_EDGE_BOTH, 1'b0, 1'b1);
    results();
  end

endmodule : step_charge_config_regs_tb
